// File: pwmfo_fault_override.sv
// fault source select, polarity, override sequencing and register slave
//
// How it works
// - five-bit field picks one of 32 sources
// - irq enable bit 12 gates fault interrupt
// - polarity bit 2 inverts selected input
// - override data bits 5:4 drive outputs
// - zero forces instantly, one via dead-time
// - interrupt still raised with override disabled
// - selected fault always goes to adc
// - fault pins readable while module enabled
// - comparators feed source codes zero to seven
// - status shows irq latch or input level
// - latched: hold until clear, exit at boundary
// - early flag clear waits for deassertion
// - writing enable zero clears the flag
// - cycle mode releases at next cycle start
// - mode field at bits 1:0
// - exit aligned to timebase counter zero
// - module disabled: exit without boundary wait
// - fault sensed from port latch when output
// - pin mode field at bits 11:10
// - fault override beats current-limit override
// - generator irq ORs trigger, limit, fault
`timescale 1ns/100ps

module pwmfo_fault_override #(
  parameter int NUM_CMP = pwmfo_pkg::NUM_CMP,
  parameter int NUM_PINS = pwmfo_pkg::NUM_PINS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire pwmfo_pkg::pwmfo_bus_s bus_in,
  output logic [31:0] rdata_out,
  input wire logic [NUM_CMP-1:0] comparator_in,
  input wire logic [NUM_PINS-1:0] fault_input_pin_in,
  input wire logic [NUM_PINS-1:0] port_direction_bit_in,
  input wire logic [NUM_PINS-1:0] port_data_in,
  input wire logic pwm_module_enable_in,
  input wire logic timebase_zero_in,
  input wire pwmfo_pkg::pwmfo_pair_s pwm_in,
  input wire pwmfo_pkg::pwmfo_pair_s deadtime_in,
  input wire logic limit_active_in,
  input wire pwmfo_pkg::pwmfo_pair_s limit_override_data_in,
  input wire logic trigger_irq_in,
  input wire logic limit_irq_in,
  output pwmfo_pkg::pwmfo_pair_s pwm_out,
  output pwmfo_pkg::pwmfo_pair_s deadtime_force_out,
  output logic override_active_out,
  output logic [1:0] output_pin_mode_out,
  output logic adc_fault_trigger_out,
  output logic fault_irq_out,
  output logic generator_irq_out
);

  // software-visible control fields
  logic [4:0] fault_source_select;
  logic fault_polarity;
  logic [1:0] fault_mode_field;
  logic fault_irq_enable;
  logic [1:0] output_pin_mode;
  pwmfo_pkg::pwmfo_pair_s fault_override_data;

  // fault flag and sequencing
  logic fault_status_flag;
  logic flag_set;
  pwmfo_pkg::pwmfo_state_e state;
  pwmfo_pkg::pwmfo_state_e next_state;

  // source vector and selected fault
  logic [NUM_CMP+NUM_PINS-1:0] sources;
  logic [NUM_PINS-1:0] pin_level;
  logic sel_raw;
  logic fault_raw;

  // three-stage synchroniser on the selected fault
  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic fault_sync;

  // filtered pin levels for the software readback
  logic [NUM_PINS-1:0] pin_stable;

  // decoded override controls
  logic mode_on;
  logic exit_ok;
  logic boundary;
  logic flag_clear;
  logic override_on;
  pwmfo_pkg::pwmfo_pair_s forced;

  // per pin: port-latch sensing and a three-stage readback filter
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      logic stage_one;
      logic stage_two;
      logic stage_three;
      logic stable;

      // a pin set as output is sensed from its own port latch
      assign pin_level[gi] = port_direction_bit_in[gi] ? fault_input_pin_in[gi] : port_data_in[gi];

      // stage one is read by stage two only, so a metastable level never fans out
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          stage_one <= 1'b0;
          stage_two <= 1'b0;
          stage_three <= 1'b0;
        end else if (ce_in) begin
          stage_one <= pin_level[gi];
          stage_two <= stage_one;
          stage_three <= stage_two;
        end
      end

      // the polled bit moves once stages two and three agree
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          stable <= 1'b0;
        end else if (ce_in && (stage_two == stage_three)) begin
          stable <= stage_three;
        end
      end

      assign pin_stable[gi] = stable;
    end
  endgenerate

  // comparators occupy source codes 0..7, pins follow
  assign sources = {pin_level, comparator_in};

  // source mux; with the package sizes all 32 codes map to a comparator or a pin
  assign sel_raw = sources[fault_source_select];

  // polarity turns an active-low source into positive logic
  assign fault_raw = sel_raw ^ fault_polarity;

  // synchroniser stages; only stage b reads stage a
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else if (ce_in) begin
      sync_a <= fault_raw;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // the level moves only once stages b and c agree, a glitch filter
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fault_sync <= 1'b0;
    end else if (ce_in && (sync_b == sync_c)) begin
      fault_sync <= sync_c;
    end
  end

  // adc trigger comes from a flop and ignores enable and mode bits
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      adc_fault_trigger_out <= 1'b0;
    end else if (ce_in) begin
      adc_fault_trigger_out <= fault_sync;
    end
  end

  // writes that carry the irq enable bit low clear the flag
  assign flag_clear = bus_in.wr && (bus_in.addr == pwmfo_pkg::GEN_CTRL_ADDR)
                      && !bus_in.wdata[pwmfo_pkg::GC_IRQ_EN_BIT];

  // control register writes
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fault_irq_enable <= 1'b0;
    end else if (ce_in && bus_in.wr && (bus_in.addr == pwmfo_pkg::GEN_CTRL_ADDR)) begin
      fault_irq_enable <= bus_in.wdata[pwmfo_pkg::GC_IRQ_EN_BIT];
    end
  end

  // fault control register: source, polarity, mode
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fault_source_select <= pwmfo_pkg::SRC_RST;
      fault_polarity <= 1'b0;
      fault_mode_field <= pwmfo_pkg::MODE_RST;
    end else if (ce_in && bus_in.wr && (bus_in.addr == pwmfo_pkg::FLT_CTRL_ADDR)) begin
      fault_source_select <= bus_in.wdata[pwmfo_pkg::FC_SRC_MSB:pwmfo_pkg::FC_SRC_LSB];
      fault_polarity <= bus_in.wdata[pwmfo_pkg::FC_POL_BIT];
      fault_mode_field <= bus_in.wdata[pwmfo_pkg::FC_MODE_MSB:pwmfo_pkg::FC_MODE_LSB];
    end
  end

  // io control register: pin mode and override data
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      output_pin_mode <= pwmfo_pkg::OUTPUT_PIN_MODE_RST;
      fault_override_data <= pwmfo_pkg::FDAT_RST;
    end else if (ce_in && bus_in.wr && (bus_in.addr == pwmfo_pkg::IO_CTRL_ADDR)) begin
      output_pin_mode <= bus_in.wdata[pwmfo_pkg::IO_OUTPUT_PIN_MODE_MSB:pwmfo_pkg::IO_OUTPUT_PIN_MODE_LSB];
      fault_override_data.high <= bus_in.wdata[pwmfo_pkg::IO_FDAT_HI_BIT];
      fault_override_data.low <= bus_in.wdata[pwmfo_pkg::IO_FDAT_LO_BIT];
    end
  end

  // pin mode is consumed by the output stage further on
  assign output_pin_mode_out = output_pin_mode;

  // a set is a new event only while the flag is low; a held fault on a flag
  // already set must not block the clear, or a latched exit could never start
  assign flag_set = fault_sync && fault_irq_enable && !fault_status_flag;

  // fault flag: set wins over a same-cycle clear so no event is lost;
  // it sets regardless of the mode field, so the pin works as a plain irq
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fault_status_flag <= 1'b0;
    end else if (ce_in) begin
      if (flag_set) begin
        fault_status_flag <= 1'b1;
      end else if (flag_clear) begin
        fault_status_flag <= 1'b0;
      end
    end
  end

  // fault interrupt and the generator's combined request
  assign fault_irq_out = fault_status_flag;
  assign generator_irq_out = trigger_irq_in | limit_irq_in | fault_status_flag;

  // modes 00 and 01 override; 11 and the unused 10 leave outputs alone
  assign mode_on = (fault_mode_field == pwmfo_pkg::MODE_LATCHED)
                   || (fault_mode_field == pwmfo_pkg::MODE_CYCLE);

  // cycle boundary is counter zero; with the module off there is none to wait for
  assign boundary = timebase_zero_in || !pwm_module_enable_in;

  // latched exit also needs the flag cleared by software first
  assign exit_ok = (fault_mode_field == pwmfo_pkg::MODE_CYCLE)
                   || !fault_status_flag;

  // override sequencing
  always_comb begin
    next_state = state;
    case (state)
      pwmfo_pkg::PWMFO_IDLE: begin
        if (fault_sync) begin
          next_state = pwmfo_pkg::PWMFO_FORCED;
        end
      end
      pwmfo_pkg::PWMFO_FORCED: begin
        // flag cleared early still holds here until the input drops
        if (!fault_sync) begin
          next_state = pwmfo_pkg::PWMFO_EXIT_WAIT;
        end
      end
      pwmfo_pkg::PWMFO_EXIT_WAIT: begin
        if (fault_sync) begin
          next_state = pwmfo_pkg::PWMFO_FORCED;
        end else if (exit_ok && boundary) begin
          next_state = pwmfo_pkg::PWMFO_IDLE;
        end
      end
      default: begin
        next_state = pwmfo_pkg::PWMFO_IDLE;
      end
    endcase
    if (!mode_on) begin
      next_state = pwmfo_pkg::PWMFO_IDLE;
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= pwmfo_pkg::PWMFO_IDLE;
    end else if (ce_in) begin
      state <= next_state;
    end
  end

  // the raw input joins the held state so entry needs no clock edge;
  // the cost is that a glitch on the pin can briefly force the outputs
  assign override_on = mode_on && (fault_raw || (state != pwmfo_pkg::PWMFO_IDLE));
  assign override_active_out = override_on;

  // a one bit is handed to the dead-time stage, which returns it shaped
  assign deadtime_force_out.high = override_on && fault_override_data.high;
  assign deadtime_force_out.low = override_on && fault_override_data.low;

  // a zero bit is forced low directly, a one takes the dead-time result
  assign forced.high = fault_override_data.high && deadtime_in.high;
  assign forced.low = fault_override_data.low && deadtime_in.low;

  // fault first, then current limit, then normal pwm
  always_comb begin
    if (override_on) begin
      pwm_out = forced;
    end else if (limit_active_in) begin
      pwm_out = limit_override_data_in;
    end else begin
      pwm_out = pwm_in;
    end
  end

  // read data one cycle after the strobe, zero elsewhere and for unmapped
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 32'h00000000;
    end else if (ce_in) begin
      rdata_out <= 32'h00000000;
      if (bus_in.rd) begin
        case (bus_in.addr)
          pwmfo_pkg::GEN_CTRL_ADDR: begin
            rdata_out[pwmfo_pkg::GC_STATUS_BIT] <= fault_irq_enable ? fault_status_flag : fault_sync;
            rdata_out[pwmfo_pkg::GC_IRQ_EN_BIT] <= fault_irq_enable;
          end
          pwmfo_pkg::FLT_CTRL_ADDR: begin
            rdata_out[pwmfo_pkg::FC_SRC_MSB:pwmfo_pkg::FC_SRC_LSB] <= fault_source_select;
            rdata_out[pwmfo_pkg::FC_POL_BIT] <= fault_polarity;
            rdata_out[pwmfo_pkg::FC_MODE_MSB:pwmfo_pkg::FC_MODE_LSB] <= fault_mode_field;
          end
          pwmfo_pkg::IO_CTRL_ADDR: begin
            rdata_out[pwmfo_pkg::IO_OUTPUT_PIN_MODE_MSB:pwmfo_pkg::IO_OUTPUT_PIN_MODE_LSB] <= output_pin_mode;
            rdata_out[pwmfo_pkg::IO_FDAT_HI_BIT] <= fault_override_data.high;
            rdata_out[pwmfo_pkg::IO_FDAT_LO_BIT] <= fault_override_data.low;
          end
          pwmfo_pkg::PIN_READ_ADDR: begin
            // polling path stays live while the module runs
            rdata_out[NUM_PINS-1:0] <= pin_stable;
          end
          default: begin
            rdata_out <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule : pwmfo_fault_override

// File: pwmfo_fault_override_sva.sv
// checker: port-level assertions for the fault override block
`timescale 1ns/100ps
module pwmfo_fault_override_sva (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire pwmfo_pkg::pwmfo_bus_s bus_in,
  input wire logic pwm_module_enable_in,
  input wire logic timebase_zero_in,
  input wire pwmfo_pkg::pwmfo_pair_s pwm_in,
  input wire pwmfo_pkg::pwmfo_pair_s deadtime_in,
  input wire logic limit_active_in,
  input wire pwmfo_pkg::pwmfo_pair_s limit_override_data_in,
  input wire logic trigger_irq_in,
  input wire logic limit_irq_in,
  input wire pwmfo_pkg::pwmfo_pair_s pwm_out,
  input wire pwmfo_pkg::pwmfo_pair_s deadtime_force_out,
  input wire logic override_active_out,
  input wire logic adc_fault_trigger_out,
  input wire logic fault_irq_out,
  input wire logic generator_irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic clr_req;
  // a write of zero to the enable bit is the only way to drop the flag
  assign clr_req = bus_in.wr && bus_in.addr == pwmfo_pkg::GEN_CTRL_ADDR && !bus_in.wdata[pwmfo_pkg::GC_IRQ_EN_BIT];
  AST_IRQ_OR: assert property (generator_irq_out == (trigger_irq_in | limit_irq_in | fault_irq_out))
    else $error("generator irq is not the or of its sources");
  AST_FORCE: assert property (override_active_out |-> pwm_out == (deadtime_force_out & deadtime_in))
    else $error("forced outputs differ from override data");
  AST_DTF_GATE: assert property (|deadtime_force_out |-> override_active_out)
    else $error("dead-time request without override");
  AST_LIMIT: assert property (!override_active_out && limit_active_in |-> pwm_out == limit_override_data_in)
    else $error("limit override not applied");
  AST_NORMAL: assert property (!override_active_out && !limit_active_in |-> pwm_out == pwm_in)
    else $error("normal pwm not passed through");
  AST_FLAG_SYNC: assert property ($rose(fault_irq_out) |-> adc_fault_trigger_out)
    else $error("flag rose ahead of the synced fault");
  AST_FLAG_CLR: assert property ($fell(fault_irq_out) |-> $past(clr_req))
    else $error("flag fell without a clear write");
  AST_EXIT: assert property ($fell(override_active_out) && $past(pwm_module_enable_in) && !$past(bus_in.wr)
    |-> $past(timebase_zero_in))
    else $error("override released off the cycle boundary");
endmodule : pwmfo_fault_override_sva
bind pwmfo_fault_override pwmfo_fault_override_sva u_pwmfo_fault_override_sva (.clk_in, .rst_in, .bus_in,
  .pwm_module_enable_in, .timebase_zero_in, .pwm_in, .deadtime_in, .limit_active_in, .limit_override_data_in,
  .trigger_irq_in, .limit_irq_in, .pwm_out, .deadtime_force_out, .override_active_out, .adc_fault_trigger_out,
  .fault_irq_out, .generator_irq_out);

// File: pwmfo_pkg.sv
// package: register map, field positions and types for the fault override block
package pwmfo_pkg;

  // register byte addresses
  localparam logic [3:0] GEN_CTRL_ADDR = 4'h0;
  localparam logic [3:0] FLT_CTRL_ADDR = 4'h4;
  localparam logic [3:0] IO_CTRL_ADDR = 4'h8;
  localparam logic [3:0] PIN_READ_ADDR = 4'hc;

  // generator_control fields
  localparam int GC_STATUS_BIT = 15;
  localparam int GC_IRQ_EN_BIT = 12;

  // fault_limit_control fields
  localparam int FC_SRC_LSB = 3;
  localparam int FC_SRC_MSB = 7;
  localparam int FC_POL_BIT = 2;
  localparam int FC_MODE_LSB = 0;
  localparam int FC_MODE_MSB = 1;

  // output_io_control fields
  localparam int IO_OUTPUT_PIN_MODE_LSB = 10;
  localparam int IO_OUTPUT_PIN_MODE_MSB = 11;
  localparam int IO_FDAT_HI_BIT = 5;
  localparam int IO_FDAT_LO_BIT = 4;

  // reset values
  localparam logic [4:0] SRC_RST = 5'h00;
  localparam logic [1:0] MODE_RST = 2'h3;
  localparam logic [1:0] OUTPUT_PIN_MODE_RST = 2'h0;
  localparam logic [1:0] FDAT_RST = 2'h0;

  // source layout
  localparam int NUM_SOURCES = 32;
  localparam int NUM_CMP = 8;
  localparam int NUM_PINS = NUM_SOURCES - NUM_CMP;

  // fault mode encodings
  localparam logic [1:0] MODE_LATCHED = 2'h0;
  localparam logic [1:0] MODE_CYCLE = 2'h1;
  localparam logic [1:0] MODE_OFF = 2'h3;

  // override sequencing states, one bit changing per step except the exit wait to idle return
  typedef enum logic [1:0] {
    PWMFO_IDLE = 2'b00,
    PWMFO_FORCED = 2'b01,
    PWMFO_EXIT_WAIT = 2'b11
  } pwmfo_state_e;

  // register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pwmfo_bus_s;

  // a pair of pwm output levels
  typedef struct packed {
    logic high;
    logic low;
  } pwmfo_pair_s;

endpackage : pwmfo_pkg

// File: pwmfo_src_model.sv
// partner model: comparators and fault pins that feed the source select
`timescale 1ns/100ps
module pwmfo_src_model (
  input wire logic [4:0] sel_in,
  input wire logic level_in,
  output wire logic [7:0] comparator_out,
  output wire logic [23:0] pins_out
);
  // only the chosen source moves; the delay keeps edges off the clock, as real sources are async
  assign #2 comparator_out = (sel_in < 5'h08) ? (8'(level_in) << sel_in[2:0]) : 8'h00;
  assign #2 pins_out = (sel_in < 5'h08) ? 24'h000000 : (24'(level_in) << 5'(sel_in - 5'h08));
endmodule : pwmfo_src_model

// File: pwmfo_tb.sv
// testbench: register, source select and override scenarios for the fault override block
`timescale 1ns/100ps
module testbench;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  pwmfo_pkg::pwmfo_bus_s bus = '0;
  pwmfo_pkg::pwmfo_pair_s pwm_in = '0, dt_in = '0, lim_data = '0, pwm_out, dtf;
  logic [31:0] rdata;
  logic [31:0] exp_q[$];
  logic [7:0] cmp;
  logic [23:0] pins, dir = 24'hffffff, pdata = 24'h000000;
  logic [4:0] sel = 5'h00;
  logic [1:0] pmode;
  logic lvl = 1'b0, en = 1'b0, tbz = 1'b0, lim_act = 1'b0, trg = 1'b0, lirq = 1'b0, rd_d = 1'b0, p;
  logic ovr, adc, firq, girq;
  logic ce = 1'b1;
  int miscompares = 0, n_tests = 0, cycles = 0;
  always #4 clk_in = ~clk_in;
  pwmfo_src_model u_pwmfo_src_model (.sel_in(sel), .level_in(lvl), .comparator_out(cmp), .pins_out(pins));
  pwmfo_fault_override u_pwmfo_fault_override (.clk_in, .rst_in, .ce_in(ce), .bus_in(bus), .rdata_out(rdata),
    .comparator_in(cmp), .fault_input_pin_in(pins), .port_direction_bit_in(dir), .port_data_in(pdata),
    .pwm_module_enable_in(en), .timebase_zero_in(tbz), .pwm_in, .deadtime_in(dt_in), .limit_active_in(lim_act),
    .limit_override_data_in(lim_data), .trigger_irq_in(trg), .limit_irq_in(lirq), .pwm_out,
    .deadtime_force_out(dtf), .override_active_out(ovr), .output_pin_mode_out(pmode),
    .adc_fault_trigger_out(adc), .fault_irq_out(firq), .generator_irq_out(girq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus <= '0;
  endtask : rd
  task automatic src(input logic [4:0] s, input logic l, input int n);
    @(posedge clk_in);
    sel <= s;
    lvl <= l;
    repeat (n) @(posedge clk_in);
  endtask : src
  task automatic tick();
    @(posedge clk_in);
    tbz <= 1'b1;
    @(posedge clk_in);
    tbz <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask : tick
  // side inputs run at random so every output mux path sees traffic; also the hang guard
  always @(posedge clk_in) begin
    {pwm_in, dt_in, lim_data, lim_act, trg, lirq} <= 9'($urandom);
    cycles <= cycles + 1;
    if (cycles > 5000) begin
      miscompares++;
      finish_test();
    end
  end
  // read data is only valid the cycle after the strobe, so it is compared exactly there
  always @(posedge clk_in) begin
    rd_d <= bus.rd;
    if (rd_d) chk(rdata, exp_q.pop_front());
  end
  // main sequence
  initial begin
    void'($urandom(73));
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h3);
    rd(4'h8, 32'h0);
    rd(4'h2, 32'h0);
    $display("reset values done");
    // every source with a random polarity, override off
    for (int i = 0; i < 32; i++) begin
      p = 1'($urandom);
      src(i[4:0], p, 1);
      wr(4'h4, {24'h0, i[4:0], p, 2'h3});
      src(i[4:0], ~p, 8);
      #1 chk(adc, 1'b1);
      chk(ovr, 1'b0);
      rd(4'h0, 32'h8000);
      src(i[4:0], p, 8);
      #1 chk(adc, 1'b0);
    end
    $display("source select done");
    // a pin turned to output still feeds the fault path from its port latch
    @(posedge clk_in) en <= 1'b1;
    src(5'h00, 1'b0, 1);
    dir <= 24'hffffdf;
    pdata <= 24'h000020;
    wr(4'h4, {24'h0, 5'h0d, 3'h3});
    repeat (8) @(posedge clk_in);
    #1 chk(adc, 1'b1);
    rd(4'hc, 32'h20);
    dir <= 24'hffffff;
    $display("pin control done");
    // latched: instant force, early flag clear, release waits for the boundary
    wr(4'h8, 32'h820);
    rd(4'h8, 32'h820);
    #1 chk(pmode, 2'h2);
    wr(4'h0, 32'h1000);
    wr(4'h4, {24'h0, 5'h08, 3'h0});
    src(5'h08, 1'b1, 0);
    #3 chk(dtf, 2'h2);
    chk(pwm_out.low, 1'b0);
    repeat (8) @(posedge clk_in);
    #1 chk(firq, 1'b1);
    rd(4'h0, 32'h9000);
    wr(4'h0, 32'h0);
    src(5'h08, 1'b1, 4);
    #1 chk(ovr, 1'b1);
    src(5'h08, 1'b0, 12);
    #1 chk(ovr, 1'b1);
    rd(4'h0, 32'h0);
    tick();
    #1 chk(ovr, 1'b0);
    wr(4'h4, {24'h0, 5'h08, 3'h0});
    rd(4'h4, 32'h40);
    $display("latched mode done");
    // cycle mode: boundary exit when running, immediate exit when the module is off
    wr(4'h4, {24'h0, 5'h08, 3'h1});
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_in) en <= (m == 0);
      src(5'h08, 1'b1, 8);
      src(5'h08, 1'b0, 10);
      #1 chk(ovr, m == 0);
      tick();
      #1 chk(ovr, 1'b0);
    end
    $display("cycle mode done");
    // override off still raises the flag, and a zero write clears it
    wr(4'h4, {24'h0, 5'h08, 3'h3});
    wr(4'h0, 32'h1000);
    src(5'h08, 1'b1, 8);
    #1 chk(firq, 1'b1);
    chk(ovr, 1'b0);
    src(5'h08, 1'b0, 8);
    wr(4'h0, 32'h0);
    #1 chk(firq, 1'b0);
    $display("irq only done");
    // a low clock enable freezes the synchroniser, so the trigger must hold still
    @(posedge clk_in) ce <= 1'b0;
    src(5'h08, 1'b1, 8);
    #1 chk(adc, 1'b0);
    @(posedge clk_in) ce <= 1'b1;
    repeat (8) @(posedge clk_in);
    #1 chk(adc, 1'b1);
    $display("clock enable done");
    finish_test();
  end
endmodule : testbench
